//--- src/ppeu_pkg.sv
// package: register map, field positions and reset values of the pin event unit control
package ppeu_pkg;
  localparam int unsigned PPEU_NUM_TRIG = 3;
  localparam int unsigned PPEU_NUM_CAP = 2;
  localparam logic [11:0] PPEU_OFF_INDEX = 12'h520;
  localparam logic [11:0] PPEU_OFF_IRQ_STATUS = 12'h524;
  localparam logic [11:0] PPEU_OFF_IRQ_MASK = 12'h528;
  localparam logic [11:0] PPEU_OFF_CTRL = 12'h52c;
  localparam logic [11:0] PPEU_OFF_TGT_NS = 12'h530;
  localparam logic [11:0] PPEU_OFF_TGT_S = 12'h534;
  localparam logic [11:0] PPEU_OFF_NOTIFY = 12'h53c;
  localparam int unsigned PPEU_IDX_TRIG_LSB = 0;
  localparam int unsigned PPEU_IDX_CAP_BIT = 8;
  localparam int unsigned PPEU_BIT_OUT_SEL = 8;
  localparam int unsigned PPEU_BIT_PIN_IN = 7;
  localparam int unsigned PPEU_BIT_DIR = 6;
  localparam int unsigned PPEU_BIT_CAP_IE = 5;
  localparam int unsigned PPEU_BIT_ACTIVE = 4;
  localparam int unsigned PPEU_BIT_TRIG_EN = 3;
  localparam int unsigned PPEU_BIT_TRIG_RST = 2;
  localparam int unsigned PPEU_BIT_CAP_EN = 1;
  localparam int unsigned PPEU_BIT_CAP_RST = 0;
  localparam int unsigned PPEU_NS_W = 30;
  localparam int unsigned PPEU_CNT_W = 4;
  // status bits: [2:0] trigger done, [6:4] trigger error, [9:8] capture ready
  localparam int unsigned PPEU_ST_DONE_LSB = 0;
  localparam int unsigned PPEU_ST_ERR_LSB = 4;
  localparam int unsigned PPEU_ST_CAP_LSB = 8;
  localparam logic [31:0] PPEU_RESET_WORD = 32'h0000_0000;
endpackage

//--- src/ppeu_trigger_unit.sv
// one event output unit: enable, compare against system time, done and error
`timescale 1ns/1ps
`default_nettype none
module ppeu_trigger_unit
  import ppeu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic soft_rst,
  input wire logic en_wr,
  input wire logic en_wdata,
  input wire logic ns_wr,
  input wire logic s_wr,
  input wire logic [31:0] wdata,
  input wire logic notify,
  input wire logic [31:0] sys_s,
  input wire logic [PPEU_NS_W-1:0] sys_ns,
  output logic en_reg,
  output logic active,
  output logic fire,
  output logic err_set,
  output logic [PPEU_NS_W-1:0] tgt_ns_reg,
  output logic [31:0] tgt_s_reg
);
  logic reached;
  logic err_reg;
  assign reached = (sys_s > tgt_s_reg) || ((sys_s == tgt_s_reg) && (sys_ns >= tgt_ns_reg));
  // target already passed at enable time is an error when notify is on
  assign err_set = ce && en_wr && en_wdata && !en_reg && reached && notify;
  assign fire = ce && en_reg && reached && !soft_rst && !en_wr;
  assign active = en_reg && !err_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n || (ce && soft_rst)) // RQ9
    begin
      en_reg <= 1'b0;
      err_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (en_wr)
      begin
        en_reg <= en_wdata && !err_set; // RQ7
        err_reg <= err_set;
      end
      else if (fire)
        en_reg <= 1'b0; // RQ7 RQ18
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n || (ce && soft_rst))
    begin
      tgt_ns_reg <= PPEU_RESET_WORD[PPEU_NS_W-1:0]; // RQ13
      tgt_s_reg <= PPEU_RESET_WORD; // RQ14
    end
    else if (ce)
    begin
      if (ns_wr)
        tgt_ns_reg <= wdata[PPEU_NS_W-1:0]; // RQ13
      if (s_wr)
        tgt_s_reg <= wdata; // RQ14
    end
  end
endmodule
`default_nettype wire

//--- src/ppeu_top.sv
// pin event unit control: apb registers, trigger and capture units, interrupt
//
// Summary of operation
// RQ1: index register steers trigger fields by two bits, capture fields by one bit.
// RQ2: bit 8 set drives pin combinationally, clear drives it from a flip-flop.
// RQ3: bit 7 reads the present level of the event pin input.
// RQ4: bit 6 set makes the pin a capture input; clear (reset) an output.
// RQ5: bit 5 gates indexed capture unit status onto the interrupt.
// RQ6: bit 4 reads one while indexed trigger unit runs without error.
// RQ7: writing one to bit 3 enables trigger unit; clears itself on firing.
// RQ8: software enables only the head unit of a cascade chain; units here are not chained, and each one is enabled by software through bit 3.
// RQ9: bit 2 returns indexed trigger unit to inactive default state.
// RQ10: writing one to bit 1 enables capture unit and clears its count.
// RQ11: writing zero to bit 1 disables unit, clears ready and overflow flags.
// RQ12: bit 0 returns indexed capture unit to inactive default state.
// RQ13: target nanoseconds is 30 bits, upper two read zero, reset zero.
// RQ14: target seconds is a full 32-bit register resetting to zero.
// RQ15: nanoseconds register accesses reach only the indexed trigger unit.
// RQ16: trigger error clears when the enable bit is written zero.
// RQ17: done and error are reported only when the unit notify bit is on.
// RQ18: enabled trigger unit fires when system time reaches its target.
// RQ19: reserved control bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module ppeu_top
  import ppeu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] sys_s,
  input wire logic [PPEU_NS_W-1:0] sys_ns,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic wr;
  logic rd;
  logic hit;
  logic rd_ok_reg;
  // read data is loaded one edge ahead so that it stands at the edge where pready is high
  assign wr = ce && psel && penable && pwrite;
  assign rd = ce && psel && !pwrite && !rd_ok_reg;
  assign pready = ce && (pwrite || rd_ok_reg);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_ok_reg <= 1'b0;
    else if (ce)
      rd_ok_reg <= psel && !pwrite && !(penable && pready);
  end
  assign hit = (paddr == PPEU_OFF_INDEX) || (paddr == PPEU_OFF_IRQ_STATUS) ||
               (paddr == PPEU_OFF_IRQ_MASK) || (paddr == PPEU_OFF_CTRL) ||
               (paddr == PPEU_OFF_TGT_NS) || (paddr == PPEU_OFF_TGT_S) ||
               (paddr == PPEU_OFF_NOTIFY);
  assign pslverr = psel && penable && pready && !hit;
  logic wr_idx;
  logic wr_ctrl;
  logic wr_ns;
  logic wr_s;
  logic wr_st;
  logic wr_mask;
  logic wr_notify;
  assign wr_idx = wr && (paddr == PPEU_OFF_INDEX);
  assign wr_ctrl = wr && (paddr == PPEU_OFF_CTRL);
  assign wr_ns = wr && (paddr == PPEU_OFF_TGT_NS);
  assign wr_s = wr && (paddr == PPEU_OFF_TGT_S);
  assign wr_st = wr && (paddr == PPEU_OFF_IRQ_STATUS);
  assign wr_mask = wr && (paddr == PPEU_OFF_IRQ_MASK);
  assign wr_notify = wr && (paddr == PPEU_OFF_NOTIFY);
  ////////////////////////////////////////////////////////////////////////////
  // index, global control and pin synchroniser
  logic [1:0] trig_idx_reg;
  logic cap_idx_reg;
  logic out_sel_reg;
  logic dir_reg;
  logic [PPEU_NUM_TRIG-1:0] notify_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      trig_idx_reg <= 2'h0;
      cap_idx_reg <= 1'b0;
    end
    else if (wr_idx)
    begin
      trig_idx_reg <= pwdata[PPEU_IDX_TRIG_LSB +: 2]; // RQ1
      cap_idx_reg <= pwdata[PPEU_IDX_CAP_BIT]; // RQ1
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_sel_reg <= 1'b0;
      dir_reg <= 1'b0; // RQ4
      notify_reg <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        out_sel_reg <= pwdata[PPEU_BIT_OUT_SEL]; // RQ2
        dir_reg <= pwdata[PPEU_BIT_DIR]; // RQ4
      end
      if (wr_notify)
        notify_reg <= pwdata[PPEU_NUM_TRIG-1:0];
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // trigger units
  logic trig_sel_ok;
  assign trig_sel_ok = trig_idx_reg < 2'(PPEU_NUM_TRIG);
  logic [PPEU_NUM_TRIG-1:0] t_en;
  logic [PPEU_NUM_TRIG-1:0] t_act;
  logic [PPEU_NUM_TRIG-1:0] t_fire;
  logic [PPEU_NUM_TRIG-1:0] t_err;
  logic [PPEU_NS_W-1:0] t_ns [PPEU_NUM_TRIG];
  logic [31:0] t_s [PPEU_NUM_TRIG];
  genvar gi;
  generate
    for (gi = 0; gi < PPEU_NUM_TRIG; gi++)
    begin : g_trig
      logic sel;
      assign sel = trig_sel_ok && (trig_idx_reg == 2'(gi)); // RQ1 RQ15
      ppeu_trigger_unit u_trig (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .soft_rst(wr_ctrl && sel && pwdata[PPEU_BIT_TRIG_RST]), // RQ9
        .en_wr(wr_ctrl && sel),
        .en_wdata(pwdata[PPEU_BIT_TRIG_EN]),
        .ns_wr(wr_ns && sel), // RQ15
        .s_wr(wr_s && sel),
        .wdata(pwdata),
        .notify(notify_reg[gi]),
        .sys_s(sys_s),
        .sys_ns(sys_ns),
        .en_reg(t_en[gi]),
        .active(t_act[gi]),
        .fire(t_fire[gi]),
        .err_set(t_err[gi]),
        .tgt_ns_reg(t_ns[gi]),
        .tgt_s_reg(t_s[gi])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // capture units
  logic [PPEU_NUM_CAP-1:0] c_en_reg;
  logic [PPEU_NUM_CAP-1:0] c_ie_reg;
  logic [PPEU_NUM_CAP-1:0] c_rdy_reg;
  logic [PPEU_NUM_CAP-1:0] c_ovf_reg;
  logic [PPEU_CNT_W-1:0] c_cnt_reg [PPEU_NUM_CAP];
  logic pin_prev_reg;
  logic pin_edge;
  assign pin_edge = dir_reg && (pin_s2_reg != pin_prev_reg);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_prev_reg <= 1'b0;
    else if (ce)
      pin_prev_reg <= pin_s2_reg;
  end
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < PPEU_NUM_CAP; i++)
    begin
      if (!rst_n)
      begin
        c_en_reg[i] <= 1'b0;
        c_ie_reg[i] <= 1'b0;
        c_rdy_reg[i] <= 1'b0;
        c_ovf_reg[i] <= 1'b0;
        c_cnt_reg[i] <= '0;
      end
      else if (wr_ctrl && (cap_idx_reg == 1'(i)) && pwdata[PPEU_BIT_CAP_RST])
      begin
        c_en_reg[i] <= 1'b0; // RQ12
        c_ie_reg[i] <= 1'b0;
        c_rdy_reg[i] <= 1'b0;
        c_ovf_reg[i] <= 1'b0;
        c_cnt_reg[i] <= '0;
      end
      else if (wr_ctrl && (cap_idx_reg == 1'(i)))
      begin
        c_en_reg[i] <= pwdata[PPEU_BIT_CAP_EN];
        c_ie_reg[i] <= pwdata[PPEU_BIT_CAP_IE]; // RQ5
        if (pwdata[PPEU_BIT_CAP_EN])
          c_cnt_reg[i] <= '0; // RQ10
        else
        begin
          c_rdy_reg[i] <= 1'b0; // RQ11
          c_ovf_reg[i] <= 1'b0; // RQ11
        end
      end
      else if (ce && c_en_reg[i] && pin_edge)
      begin
        c_rdy_reg[i] <= 1'b1;
        if (&c_cnt_reg[i])
          c_ovf_reg[i] <= 1'b1;
        else
          c_cnt_reg[i] <= c_cnt_reg[i] + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin output
  logic fire_comb;
  logic pin_q_reg;
  assign fire_comb = |t_fire;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_q_reg <= 1'b0;
    end
    else if (ce)
    begin
      pin_q_reg <= fire_comb;
    end
  end
  assign pin_out = out_sel_reg ? fire_comb : pin_q_reg; // RQ2
  assign pin_oe_n = dir_reg; // RQ4
  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  logic [31:0] st_reg;
  logic [31:0] mask_reg;
  logic [31:0] st_set;
  always_comb
  begin
    st_set = '0;
    st_set[PPEU_ST_DONE_LSB +: PPEU_NUM_TRIG] = t_fire & notify_reg; // RQ17
    st_set[PPEU_ST_ERR_LSB +: PPEU_NUM_TRIG] = t_err & notify_reg; // RQ17
    st_set[PPEU_ST_CAP_LSB +: PPEU_NUM_CAP] = c_rdy_reg & c_ie_reg; // RQ5
  end
  logic [31:0] err_clr;
  always_comb
  begin
    err_clr = '0;
    for (int i = 0; i < PPEU_NUM_TRIG; i++)
      if (wr_ctrl && trig_sel_ok && (trig_idx_reg == 2'(i)) && !pwdata[PPEU_BIT_TRIG_EN])
        err_clr[PPEU_ST_ERR_LSB + i] = 1'b1; // RQ16
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= PPEU_RESET_WORD;
    else
      st_reg <= (st_reg & ~(wr_st ? pwdata : 32'h0) & ~err_clr) | (ce ? st_set : 32'h0);
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mask_reg <= PPEU_RESET_WORD;
    else if (wr_mask)
      mask_reg <= pwdata;
  end
  assign irq = |(st_reg & mask_reg);
  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [31:0] ctrl_rd;
  always_comb
  begin
    ctrl_rd = '0; // RQ19
    ctrl_rd[PPEU_BIT_OUT_SEL] = out_sel_reg;
    ctrl_rd[PPEU_BIT_PIN_IN] = pin_s2_reg; // RQ3
    ctrl_rd[PPEU_BIT_DIR] = dir_reg;
    ctrl_rd[PPEU_BIT_CAP_IE] = c_ie_reg[cap_idx_reg];
    ctrl_rd[PPEU_BIT_ACTIVE] = trig_sel_ok && t_act[trig_idx_reg]; // RQ6
    ctrl_rd[PPEU_BIT_TRIG_EN] = trig_sel_ok && t_en[trig_idx_reg];
    ctrl_rd[PPEU_BIT_CAP_EN] = c_en_reg[cap_idx_reg];
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= PPEU_RESET_WORD;
    else if (rd)
    begin
      case (paddr)
        PPEU_OFF_INDEX: prdata <= {23'h0, cap_idx_reg, 6'h0, trig_idx_reg};
        PPEU_OFF_IRQ_STATUS: prdata <= st_reg;
        PPEU_OFF_IRQ_MASK: prdata <= mask_reg;
        PPEU_OFF_CTRL: prdata <= ctrl_rd;
        PPEU_OFF_TGT_NS: prdata <= trig_sel_ok ? {2'h0, t_ns[trig_idx_reg]} : 32'h0; // RQ13
        PPEU_OFF_TGT_S: prdata <= trig_sel_ok ? t_s[trig_idx_reg] : 32'h0;
        PPEU_OFF_NOTIFY: prdata <= {29'h0, notify_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence en_write_s;
    wr_ctrl && trig_sel_ok && (trig_idx_reg == 2'h0) && pwdata[PPEU_BIT_TRIG_EN] && !t_err[0];
  endsequence
  sequence flop_path_s;
    ce && !out_sel_reg ##1 !out_sel_reg;
  endsequence
  trig_self_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    t_fire[0] |=> !t_en[0]) else $error("trigger enable did not self clear");
  trig_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    en_write_s and !pwdata[PPEU_BIT_TRIG_RST] |=> t_en[0]) else $error("enable lost");
  pin_dir_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    wr_ctrl |=> pin_oe_n == $past(pwdata[PPEU_BIT_DIR])) else $error("pin direction wrong");
  pin_source_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    flop_path_s |-> pin_out == $past(fire_comb)) else $error("flopped output");
  done_notify_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ17
    ce && t_fire[0] && !notify_reg[0] && !st_reg[0] |=> !st_reg[0])
    else $error("done reported without notify");
  err_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    err_clr[PPEU_ST_ERR_LSB] && !st_set[PPEU_ST_ERR_LSB] |=> !st_reg[PPEU_ST_ERR_LSB])
    else $error("error not cleared");
  cap_disable_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    wr_ctrl && !cap_idx_reg && !pwdata[PPEU_BIT_CAP_EN] |=> !c_rdy_reg[0] && !c_ovf_reg[0])
    else $error("capture flags not cleared");
  cap_arm_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    wr_ctrl && !cap_idx_reg && pwdata[PPEU_BIT_CAP_EN] && !pwdata[PPEU_BIT_CAP_RST]
    |=> c_cnt_reg[0] == 4'h0 && c_en_reg[0]) else $error("capture arm failed");
  trig_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    wr_ctrl && (trig_idx_reg == 2'h0) && pwdata[PPEU_BIT_TRIG_RST] && ce
    |=> !t_en[0] && t_s[0] == 32'h0) else $error("trigger reset failed");
  fire_time_a: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    t_fire[0] |-> (sys_s > t_s[0]) || ((sys_s == t_s[0]) && (sys_ns >= t_ns[0])))
    else $error("fired before target");
endmodule
`default_nettype wire

//--- testbench/test_ptp_pin_event_unit_control.sv
// testbench: register-level checks of the pin event unit control over apb
`timescale 1ns/1ps
`default_nettype none
module test_ptp_pin_event_unit_control
  import ppeu_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] sys_s = 32'h0000_0005;
  logic [PPEU_NS_W-1:0] sys_ns = 30'h0000_0000;
  logic pin_in = 1'b0;
  logic pin_out;
  logic pin_oe_n;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_pulse = 0;
  time pulse_t = 0;
  int lat1;
  int lat2;

  ppeu_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_s(sys_s), .sys_ns(sys_ns), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq));

  always #25 clk = ~clk;

  // counts trigger pulses seen on the pin and when the last one came
  always @(posedge clk)
  begin
    if (pin_out === 1'b1)
    begin
      n_pulse++;
      pulse_t = $time;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; write lands and read data is taken at the edge where pready is high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(name, rdat & m, e);
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // arms unit u with a future target, then moves system time onto it
  task automatic fire(input int u, input logic sel, output int lat);
    time t0;
    wr(PPEU_OFF_INDEX, u);
    wr(PPEU_OFF_TGT_S, 32'h0000_0005);
    wr(PPEU_OFF_TGT_NS, 32'h0000_0064 + u);
    wr(PPEU_OFF_CTRL, {23'h0, sel, 8'h08});
    rdc("ctrl armed", PPEU_OFF_CTRL, 32'h0000_0018, 32'h0000_0018);
    sys_ns <= 30'h0000_0064 + u;
    t0 = $time;
    repeat (6) @(posedge clk);
    lat = int'((pulse_t - t0) / 50);
    rdc("ctrl fired", PPEU_OFF_CTRL, 32'h0000_0018, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("ctrl reset", PPEU_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
    rdc("ns reset", PPEU_OFF_TGT_NS, 32'hffff_ffff, 32'h0000_0000);
    rdc("s reset", PPEU_OFF_TGT_S, 32'hffff_ffff, 32'h0000_0000);
    chk("oe reset", {31'h0, pin_oe_n}, 32'h0000_0000);
    rdc("unmapped", 12'h540, 32'hffff_ffff, 32'h0000_0000);
    chk("slverr", {31'h0, rerr}, 32'h0000_0001);
    done_test("reset");
    for (int u = 0; u < 3; u++)
    begin
      wr(PPEU_OFF_INDEX, u);
      wr(PPEU_OFF_TGT_NS, 32'hffff_fff0 + u);
      wr(PPEU_OFF_TGT_S, 32'ha5a5_0000 + u);
    end
    for (int u = 0; u < 3; u++)
    begin
      wr(PPEU_OFF_INDEX, u);
      rdc("target ns", PPEU_OFF_TGT_NS, 32'hffff_ffff, 32'h3fff_fff0 + u);
      rdc("target s", PPEU_OFF_TGT_S, 32'hffff_ffff, 32'ha5a5_0000 + u);
    end
    done_test("targets");
    wr(PPEU_OFF_INDEX, 32'h0000_0000);
    wr(PPEU_OFF_CTRL, 32'hffff_ff60);
    chk("oe input", {31'h0, pin_oe_n}, 32'h0000_0001);
    pin_in <= 1'b1;
    repeat (4) @(posedge clk);
    rdc("ctrl pin", PPEU_OFF_CTRL, 32'hffff_ffff, 32'h0000_01e0);
    pin_in <= 1'b0;
    wr(PPEU_OFF_INDEX, 32'h0000_0100);
    rdc("ie other", PPEU_OFF_CTRL, 32'h0000_0020, 32'h0000_0000);
    wr(PPEU_OFF_CTRL, 32'h0000_0000);
    done_test("control");
    wr(PPEU_OFF_NOTIFY, 32'h0000_0006);
    wr(PPEU_OFF_IRQ_MASK, 32'h0000_0002);
    fire(0, 1'b0, lat1);
    rdc("no notify", PPEU_OFF_IRQ_STATUS, 32'h0000_0077, 32'h0000_0000);
    fire(1, 1'b0, lat1);
    fire(2, 1'b1, lat2);
    chk("pulses", n_pulse, 32'h0000_0003);
    chk("out source", lat1 - lat2, 32'h0000_0001);
    rdc("done", PPEU_OFF_IRQ_STATUS, 32'h0000_0077, 32'h0000_0006);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    wr(PPEU_OFF_IRQ_STATUS, 32'h0000_0002);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(PPEU_OFF_IRQ_MASK, 32'h0000_0004);
    chk("irq unmask", {31'h0, irq}, 32'h0000_0001);
    wr(PPEU_OFF_IRQ_STATUS, 32'h0000_0004);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    // clock enable low must hold an armed unit back even once its target time is reached
    wr(PPEU_OFF_INDEX, 32'h0000_0001);
    wr(PPEU_OFF_TGT_NS, 32'h0000_0200);
    wr(PPEU_OFF_CTRL, 32'h0000_0008);
    ce <= 1'b0;
    sys_ns <= 30'h0000_0200;
    repeat (4) @(posedge clk);
    chk("frozen", n_pulse, 32'h0000_0003);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk("thawed", n_pulse, 32'h0000_0004);
    rdc("thawed ctrl", PPEU_OFF_CTRL, 32'h0000_0018, 32'h0000_0000);
    done_test("trigger");
    wr(PPEU_OFF_NOTIFY, 32'h0000_0007);
    wr(PPEU_OFF_INDEX, 32'h0000_0000);
    wr(PPEU_OFF_TGT_S, 32'h0000_0000);
    wr(PPEU_OFF_TGT_NS, 32'h0000_0000);
    wr(PPEU_OFF_CTRL, 32'h0000_0008);
    rdc("err set", PPEU_OFF_IRQ_STATUS, 32'h0000_0070, 32'h0000_0010);
    rdc("err inactive", PPEU_OFF_CTRL, 32'h0000_0010, 32'h0000_0000);
    wr(PPEU_OFF_CTRL, 32'h0000_0000);
    rdc("err clear", PPEU_OFF_IRQ_STATUS, 32'h0000_0070, 32'h0000_0000);
    wr(PPEU_OFF_TGT_S, 32'h0000_0007);
    wr(PPEU_OFF_TGT_NS, 32'h0000_0123);
    wr(PPEU_OFF_CTRL, 32'h0000_0008);
    wr(PPEU_OFF_CTRL, 32'h0000_0004);
    rdc("rst ns", PPEU_OFF_TGT_NS, 32'hffff_ffff, 32'h0000_0000);
    rdc("rst s", PPEU_OFF_TGT_S, 32'hffff_ffff, 32'h0000_0000);
    rdc("rst ctrl", PPEU_OFF_CTRL, 32'h0000_0018, 32'h0000_0000);
    wr(PPEU_OFF_CTRL, 32'h0000_0000);
    done_test("error and reset");
    wr(PPEU_OFF_IRQ_MASK, 32'h0000_0100);
    for (int k = 0; k < 2; k++)
    begin
      wr(PPEU_OFF_CTRL, 32'h0000_0062);
      pin_in <= 1'b1;
      repeat (4) @(posedge clk);
      pin_in <= 1'b0;
      repeat (4) @(posedge clk);
      rdc("ready", PPEU_OFF_IRQ_STATUS, 32'h0000_0300, 32'h0000_0100);
      chk("irq ready", {31'h0, irq}, 32'h0000_0001);
      wr(PPEU_OFF_CTRL, k ? 32'h0000_0063 : 32'h0000_0060);
      wr(PPEU_OFF_IRQ_STATUS, 32'h0000_0300);
      rdc("ready off", PPEU_OFF_IRQ_STATUS, 32'h0000_0300, 32'h0000_0000);
      chk("irq off", {31'h0, irq}, 32'h0000_0000);
    end
    wr(PPEU_OFF_CTRL, 32'h0000_0000);
    done_test("capture");
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire
